// File: tb/rsq_far_side.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Board-side reset source: drives the external reset pin
module rsq_far_side #(
	parameter int MIN_LOW_CYC = 400
) (
	input wire logic clk,
	input wire logic pressReq,
	output logic extResetN
);
	// Pin is pulled up on the board, so it idles high
	logic pinLow = 1'b0;
	int lowCnt = 0; // Cycles spent low so far
	assign extResetN = ~pinLow;
	// A short press is stretched to the minimum width, never cut short
	always @(posedge clk) begin
		if (pressReq || (lowCnt != 0 && lowCnt < MIN_LOW_CYC)) begin
			pinLow <= 1'b1;
			lowCnt <= lowCnt + 1;
		end else begin
			pinLow <= 1'b0;
			lowCnt <= 0;
		end
	end
endmodule : rsq_far_side

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic pready, pslverr, extResetN, pressReq = 1'b0;
	logic [4:0] src = 5'h00; // Requests {pin,poc,wdt,clm,lvi}
	logic irqReq = 1'b0, irqMaskFlag = 1'b0, irqPriorityFlag = 1'b0;
	logic inServicePriority = 1'b0, irqAcceptEnable = 1'b0;
	logic coreReset, cpuClkEn, ringOscRun, mainOscRun, vectorFetch;
	logic wakeVector, wakeResume, retainStop, watchdogUnitReset;
	logic lowVoltageUnitReset, resetIndOut, resetIndOe;
	logic [15:0] pcLoadAddr, memSizeOut;
	logic [7:0] pswInit, oscSettleSel;
	logic [31:0] portOut, portOe, clkCtlOut;
	int n_fail = 0, checked = 0, cycles = 0;
	wire [1:0] ev = {wakeVector | wakeResume, vectorFetch};

	// Fast ring tick and short settle keep the run brief
	rsq_reset_sequencer #(.RING_OSC_PERIOD_NS(25), .SETTLE_SHIFT(0),
		.PORTS(4)) dut (
		.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.extResetN(extResetN), .watchdogOverflow(src[2]),
		.clockFailure(src[1]), .powerOnClearLow(src[3]),
		.lowVoltageLow(src[0]), .irqReq(irqReq),
		.irqMaskFlag(irqMaskFlag), .irqPriorityFlag(irqPriorityFlag),
		.inServicePriority(inServicePriority),
		.irqAcceptEnable(irqAcceptEnable), .coreReset(coreReset),
		.cpuClkEn(cpuClkEn), .ringOscRun(ringOscRun),
		.mainOscRun(mainOscRun), .vectorFetch(vectorFetch),
		.pcLoadAddr(pcLoadAddr), .pswInit(pswInit),
		.wakeVector(wakeVector), .wakeResume(wakeResume),
		.retainStop(retainStop), .watchdogUnitReset(watchdogUnitReset),
		.lowVoltageUnitReset(lowVoltageUnitReset), .portOut(portOut),
		.portOe(portOe), .resetIndOut(resetIndOut),
		.resetIndOe(resetIndOe), .clkCtlOut(clkCtlOut),
		.memSizeOut(memSizeOut), .oscSettleSel(oscSettleSel));
	rsq_far_side #(.MIN_LOW_CYC(rsq_pkg::EXT_RESET_MIN_CYC)) farSide (
		.clk(clk), .pressReq(pressReq), .extResetN(extResetN));

	////////////////////////////////////////////////////////////////////
	// 25 ns clock
	initial begin
		forever #12.5 clk = ~clk;
	end

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One APB transfer; idle cycle after so psel is never set twice
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			n_fail++;
			$display("CHECK FAILED pready expected 1 seen %b", pready);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// Counts falling edges until an event; pulses are caught there
	task automatic wait_ev(input int b, output int n,
		output logic [1:0] wk);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ev[b] !== 1'b1 && n < 3000);
		wk = {wakeVector, wakeResume};
		@(posedge clk);
	endtask : wait_ev

	// Single exit point
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	// Hang guard, far above the fifteen hundred or so cycles needed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] rd;
		logic er;
		int n;
		logic [1:0] wk;
		logic [4:0] s;
		logic e;
		logic [2:0] rows [5] = '{3'b000, 3'b010, 3'b101, 3'b110, 3'b111};
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk("coreReset", 1, coreReset);
		chk("portOe", 0, portOe);
		chk("resetIndOut", 0, resetIndOut);
		chk("resetIndOe", 1, resetIndOe);
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		wait_ev(0, n, wk);
		chk("clock stop", 1, n >= 17 && n <= 30);
		chk("pc", 16'h0000, pcLoadAddr);
		chk("psw", 8'h02, pswInit);
		apb(0, 12'hFFC, 32'h00000000, rd, er);
		chk("unmapped err", 1, er);
		apb(1, rsq_pkg::REG_PORT_OUT, 32'h11223344, rd, er);
		apb(1, rsq_pkg::REG_PORT_DIR, 32'h00000000, rd, er);
		apb(1, rsq_pkg::REG_CLK, 32'hA5A5A5A5, rd, er);
		apb(1, rsq_pkg::REG_OSC_SETTLE_TIME_SELECT, 32'h00000007, rd, er);
		apb(1, rsq_pkg::REG_MEM, 32'h00001234, rd, er);
		@(negedge clk);
		chk("portOe run", 32'hFFFFFFFF, portOe);
		chk("portOut run", 32'h11223344, portOut);
		chk("cpuClkEn run", 1, cpuClkEn);
		@(posedge clk);
		$display("test power-up done");
		// Each source in turn: pin, poc, wdt, clm, lvi
		for (int i = 4; i >= 0; i--) begin
			apb(1, rsq_pkg::REG_CTRL, 32'h00000001, rd, er);
			@(negedge clk);
			chk("indicator high", 1, resetIndOut);
			@(posedge clk);
			s = 5'h01 << i;
			pressReq <= s[4];
			src <= {1'b0, s[3:0]};
			repeat (8) @(posedge clk);
			@(negedge clk);
			chk("reset on", 1, coreReset);
			chk("pins float", 0, portOe);
			chk("indicator low", 0, resetIndOut);
			chk("ring osc", !s[4], ringOscRun);
			chk("main osc", !s[4], mainOscRun);
			chk("lvd reset", !s[0], lowVoltageUnitReset);
			chk("wdt reset", 1, watchdogUnitReset);
			@(posedge clk);
			if (s[4]) begin
				repeat (rsq_pkg::EXT_RESET_MIN_CYC) @(posedge clk);
			end
			pressReq <= 1'b0;
			src <= 5'h00;
			wait_ev(0, n, wk);
			chk("release", 1, n >= 17 && n <= 30);
			apb(0, rsq_pkg::REG_STATUS, 32'h00000000, rd, er);
			chk("cause", {23'h0, s, 4'h2}, rd & 32'h000001FF);
			if (i == 4) begin
				apb(0, rsq_pkg::REG_PORT_DIR, 32'h00000000, rd, er);
				chk("port dir", 32'hFFFFFFFF, rd);
				apb(0, rsq_pkg::REG_PORT_OUT, 32'h00000000, rd, er);
				chk("port latch", 32'h00220000, rd);
				chk("settle sel", 8'h05, oscSettleSel);
				chk("clock regs", 32'h00000000, clkCtlOut);
				chk("mem size", 16'hCF0C, memSizeOut);
			end
			$display("test source %0d done", i);
		end
		// Deep stop: masked request holds, unmasked wakes per table
		for (int r = 0; r < 5; r++) begin
			apb(1, rsq_pkg::REG_CTRL, 32'h00000002, rd, er);
			{irqPriorityFlag, irqAcceptEnable, inServicePriority} <= rows[r];
			irqMaskFlag <= 1'b1;
			irqReq <= 1'b1;
			repeat (40) @(posedge clk);
			@(negedge clk);
			chk("masked holds", 0, cpuClkEn);
			chk("stop osc", 0, mainOscRun);
			@(posedge clk);
			irqMaskFlag <= 1'b0;
			wait_ev(1, n, wk);
			chk("settle", 1, n >= 32 && n <= 40);
			e = rows[r][1] & (~rows[r][2] | rows[r][0]);
			chk("wake kind", {e, ~e}, wk);
			irqReq <= 1'b0;
			$display("test wake row %0d done", r);
		end
		// Pin reset out of deep stop
		apb(1, rsq_pkg::REG_CTRL, 32'h00000003, rd, er);
		pressReq <= 1'b1;
		repeat (8) @(posedge clk);
		apb(0, rsq_pkg::REG_STATUS, 32'h00000000, rd, er);
		chk("settling", 32'h0000000C, rd & 32'h0000000F);
		@(negedge clk);
		chk("retain", 1, retainStop);
		chk("stop float", 0, portOe);
		chk("stop indicator", 0, resetIndOut);
		@(posedge clk);
		repeat (rsq_pkg::EXT_RESET_MIN_CYC) @(posedge clk);
		pressReq <= 1'b0;
		wait_ev(0, n, wk);
		chk("stop release", 1, n >= 17 && n <= 30);
		$display("test stop by pin done");
		report_and_stop();
	end
endmodule : testbench

// File: verilog/rsq_pkg.sv
package rsq_pkg;

	// Clock and timing figures
	localparam int CLK_PERIOD_NS = 25;
	localparam int RING_STOP_PERIODS = 17;
	localparam int EXT_RESET_MIN_NS = 10000;
	localparam int EXT_RESET_MIN_CYC =
		(EXT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Reset values handed to the core and the peripherals
	localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
	localparam logic [7:0] PSW_RESET = 8'h02;
	localparam logic [7:0] PORT_LATCH_RESET = 8'h00;
	localparam logic [7:0] PORT_DIR_RESET = 8'hFF;
	localparam logic [7:0] OSC_SETTLE_TIME_SELECT_RESET = 8'h05;
	localparam logic [7:0] CLK_REG_RESET = 8'h00;
	localparam logic [7:0] IMS_RESET = 8'hCF;
	localparam logic [7:0] IXS_RESET = 8'h0C;

	// Register byte addresses
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_PORT_OUT = 12'h008;
	localparam logic [11:0] REG_PORT_DIR = 12'h00C;
	localparam logic [11:0] REG_OSC_SETTLE_TIME_SELECT = 12'h010;
	localparam logic [11:0] REG_CLK = 12'h014;
	localparam logic [11:0] REG_MEM = 12'h018;

	// Field positions
	localparam int CTRL_IND_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int STAT_STOPHELD_BIT = 3;
	localparam int STAT_CAUSE_LSB = 4;
	localparam int PORT_W = 8;
	localparam int PORT_UNDEF_IDX = 2;
	localparam int OSC_SETTLE_TIME_SELECT_SEL_W = 3;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_RESET,
		ST_CLKSTOP,
		ST_RUN,
		ST_STOP,
		ST_WAKE
	} rsq_state_type;

endpackage : rsq_pkg

// File: verilog/rsq_reset_sequencer.sv
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - Pin reset in deep stop waits settle time
// - Unmasked interrupt wakes; masked keeps stop
// - Five sources raise the reset request
// - Any reset restarts at the reset vector
// - Reset held while any source is active
// - Pins float during reset and clock stop
// - Pin release: seventeen ring periods, then run
// - Watchdog and monitor resets self-release likewise
// - Supply resets release once supply recovers
// - Pin reset stops both oscillators
// - Stop contents kept while reset asserted
// - Low-voltage reset spares its own detector from its second reset cycle on
// - Watchdog reset also resets the watchdog
// - Indicator bit low on reset, software raises
// - Vector loaded, status word 02H
// - Port latches clear, port two kept
// - Port directions set to all inputs
// - Settle select register reloads 05H
// - Clock control registers clear to 00H
// - Memory size registers reload CFH, 0CH
module rsq_reset_sequencer #(
	parameter int RING_OSC_PERIOD_NS = 125,
	parameter int SETTLE_SHIFT = 4,
	parameter int PORTS = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic extResetN,
	input wire logic watchdogOverflow,
	input wire logic clockFailure,
	input wire logic powerOnClearLow,
	input wire logic lowVoltageLow,
	input wire logic irqReq,
	input wire logic irqMaskFlag,
	input wire logic irqPriorityFlag,
	input wire logic inServicePriority,
	input wire logic irqAcceptEnable,
	output logic coreReset,
	output logic cpuClkEn,
	output logic ringOscRun,
	output logic mainOscRun,
	output logic vectorFetch,
	output logic [15:0] pcLoadAddr,
	output logic [7:0] pswInit,
	output logic wakeVector,
	output logic wakeResume,
	output logic retainStop,
	output logic watchdogUnitReset,
	output logic lowVoltageUnitReset,
	output logic [8*PORTS-1:0] portOut,
	output logic [8*PORTS-1:0] portOe,
	output logic resetIndOut,
	output logic resetIndOe,
	output logic [31:0] clkCtlOut,
	output logic [15:0] memSizeOut,
	output logic [7:0] oscSettleSel
);

	////////////////////////////////////////////////////////////////////
	// Derived timing

	// Ring period rounded up to whole system clocks, at least one
	localparam int RING_DIV =
		(RING_OSC_PERIOD_NS + rsq_pkg::CLK_PERIOD_NS - 1)
		/ rsq_pkg::CLK_PERIOD_NS;
	localparam logic [7:0] DIV_LAST = 8'(RING_DIV - 1);
	localparam logic [15:0] STOP_LAST =
		16'(rsq_pkg::RING_STOP_PERIODS - 1);
	localparam int PW = 8 * PORTS;

	////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		rsq_pkg::rsq_state_type st;  // Sequencer state
		logic [2:0] extSync;         // Pin synchroniser, bit 0 first
		logic [2:0] pocSync;         // Supply comparator synchroniser
		logic [2:0] lviSync;         // Low-voltage synchroniser
		logic extReq;                // Filtered pin reset request
		logic pocReq;                // Filtered power-on-clear request
		logic lviReq;                // Filtered low-voltage request
		logic [15:0] cnt;            // Settle or clock-stop counter
		logic [7:0] div;             // Ring oscillator divider
		logic tick;                  // One pulse per ring period
		logic [4:0] cause;           // ext, poc, wdt, clm, lvi
		logic fromStop;              // Reset began in deep stop
		logic ind;                   // Indicator bit latch
		logic [PW-1:0] portLatch;    // Port output latches
		logic [PW-1:0] portDir;      // Port directions, 1 = input
		logic [7:0] osc_settle_time_select;            // Settle time select
		logic [31:0] clkCtl;         // Four clock control bytes
		logic [15:0] memSize;        // Memory size bytes
		logic [31:0] rdata;          // Read data for the bus
		logic vecP;                  // Fetch through vector pulse
		logic wakeVecP;              // Wake into interrupt pulse
		logic wakeResP;              // Wake into next instruction
		logic [7:0] probeTicks;      // Ring ticks seen in clock stop
	} rsq_regs_type;

	rsq_regs_type q;  // Registered state
	rsq_regs_type d;  // Next state

	logic anyReq;    // Combined reset request
	logic setup;     // Bus setup phase
	logic access;    // Bus access phase
	logic wrOk;      // Write accepted this edge
	logic serviceOk; // Woken interrupt would be serviced
	logic hiZ;       // Pins float
	logic [15:0] settleCyc;

	////////////////////////////////////////////////////////////////////
	// Helpers

	// Address decode, shared by the error answer and the write path
	function automatic logic regMapped(input logic [11:0] a);
		regMapped = (a == rsq_pkg::REG_CTRL) ||
			(a == rsq_pkg::REG_STATUS) ||
			(a == rsq_pkg::REG_PORT_OUT) ||
			(a == rsq_pkg::REG_PORT_DIR) ||
			(a == rsq_pkg::REG_OSC_SETTLE_TIME_SELECT) ||
			(a == rsq_pkg::REG_CLK) ||
			(a == rsq_pkg::REG_MEM);
	endfunction : regMapped

	// Settle time doubles for each step of the select field
	assign settleCyc = 16'(32'd1 << (32'(q.osc_settle_time_select[rsq_pkg::OSC_SETTLE_TIME_SELECT_SEL_W-1:0])
		+ SETTLE_SHIFT));

	// Any of the five sources holds the reset
	assign anyReq = q.extReq | q.pocReq | q.lviReq |
		watchdogOverflow | clockFailure;

	assign setup = psel & ~penable;
	assign access = psel & penable;
	// Writes are dropped while the reset reload owns the registers
	assign wrOk = access & pwrite & regMapped(paddr) &
		(q.st != rsq_pkg::ST_RESET);
	// Priority flag set needs an in-service slot as well
	assign serviceOk = irqAcceptEnable &
		(~irqPriorityFlag | inServicePriority);

	////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		d = q;
		// Three-stage synchronisers, level taken when stages two and
		// three agree so a single metastable sample never counts
		d.extSync = {q.extSync[1:0], extResetN};
		d.pocSync = {q.pocSync[1:0], powerOnClearLow};
		d.lviSync = {q.lviSync[1:0], lowVoltageLow};
		if (q.extSync[1] == q.extSync[2]) begin
			d.extReq = ~q.extSync[2];
		end
		if (q.pocSync[1] == q.pocSync[2]) begin
			d.pocReq = q.pocSync[2];
		end
		if (q.lviSync[1] == q.lviSync[2]) begin
			d.lviReq = q.lviSync[2];
		end

		// Ring oscillator model; frozen while the pin holds reset
		d.tick = 1'b0;
		if (q.extReq) begin
			d.div = '0;
		end else if (q.div == DIV_LAST) begin
			d.div = '0;
			d.tick = 1'b1;
		end else begin
			d.div = q.div + 8'h01;
		end

		d.vecP = 1'b0;
		d.wakeVecP = 1'b0;
		d.wakeResP = 1'b0;

		// Read data is captured in setup so it comes from a flop
		if (setup) begin
			unique case (paddr)
				rsq_pkg::REG_CTRL: begin
					d.rdata = 32'h0000_0000;
					d.rdata[rsq_pkg::CTRL_IND_BIT] = q.ind;
				end
				rsq_pkg::REG_STATUS: begin
					d.rdata = 32'(q.st);
					d.rdata[rsq_pkg::STAT_STOPHELD_BIT] = q.fromStop;
					d.rdata[rsq_pkg::STAT_CAUSE_LSB +: 5] = q.cause;
				end
				rsq_pkg::REG_PORT_OUT: d.rdata = 32'(q.portLatch);
				rsq_pkg::REG_PORT_DIR: d.rdata = 32'(q.portDir);
				rsq_pkg::REG_OSC_SETTLE_TIME_SELECT: d.rdata = 32'(q.osc_settle_time_select);
				rsq_pkg::REG_CLK: d.rdata = q.clkCtl;
				rsq_pkg::REG_MEM: d.rdata = 32'(q.memSize);
				default: d.rdata = 32'h0000_0000;
			endcase
		end

		// Register writes
		if (wrOk) begin
			unique case (paddr)
				rsq_pkg::REG_CTRL: begin
					d.ind = pwdata[rsq_pkg::CTRL_IND_BIT];
				end
				rsq_pkg::REG_PORT_OUT: d.portLatch = pwdata[PW-1:0];
				rsq_pkg::REG_PORT_DIR: d.portDir = pwdata[PW-1:0];
				rsq_pkg::REG_OSC_SETTLE_TIME_SELECT: d.osc_settle_time_select = pwdata[7:0];
				rsq_pkg::REG_CLK: d.clkCtl = pwdata;
				rsq_pkg::REG_MEM: d.memSize = pwdata[15:0];
				default: d.memSize = q.memSize;
			endcase
		end

		// Sequencer
		unique case (q.st)
			rsq_pkg::ST_RESET: begin
				d.cause = q.cause | {q.extReq, q.pocReq,
					watchdogOverflow, clockFailure, q.lviReq};
				// Release only on a ring tick, so the stop count
				// starts aligned to the oscillator
				if (!anyReq && q.tick) begin
					d.st = rsq_pkg::ST_CLKSTOP;
					d.cnt = '0;
				end
			end
			rsq_pkg::ST_CLKSTOP: begin
				if (anyReq) begin
					d.st = rsq_pkg::ST_RESET;
					d.cause = '0;
				end else if (q.tick) begin
					d.cnt = q.cnt + 16'h0001;
					if (q.cnt == STOP_LAST) begin
						d.st = rsq_pkg::ST_RUN;
						d.vecP = 1'b1;
						d.fromStop = 1'b0;
					end
				end
			end
			rsq_pkg::ST_RUN: begin
				if (anyReq) begin
					d.st = rsq_pkg::ST_RESET;
					d.cause = '0;
				end else if (wrOk && paddr == rsq_pkg::REG_CTRL &&
					pwdata[rsq_pkg::CTRL_STOP_BIT]) begin
					d.st = rsq_pkg::ST_STOP;
				end
			end
			rsq_pkg::ST_STOP: begin
				d.cnt = '0;
				if (q.extReq) begin
					// Pin reset waits for the oscillator first
					d.st = rsq_pkg::ST_WAKE;
					d.fromStop = 1'b1;
				end else if (anyReq) begin
					d.st = rsq_pkg::ST_RESET;
					d.cause = '0;
					d.fromStop = 1'b1;
				end else if (irqReq && !irqMaskFlag) begin
					d.st = rsq_pkg::ST_WAKE;
				end
			end
			rsq_pkg::ST_WAKE: begin
				d.cnt = q.cnt + 16'h0001;
				if (!q.fromStop && anyReq) begin
					d.st = rsq_pkg::ST_RESET;
					d.cause = '0;
				end else if (q.cnt >= settleCyc - 16'h0001) begin
					if (q.fromStop) begin
						d.st = rsq_pkg::ST_RESET;
						d.cause = '0;
					end else begin
						d.st = rsq_pkg::ST_RUN;
						d.wakeVecP = serviceOk;
						d.wakeResP = ~serviceOk;
					end
				end
			end
		endcase

		// Documented reset values reload for as long as reset stands;
		// the port two latch keeps whatever it held
		if (q.st == rsq_pkg::ST_RESET) begin
			d.ind = 1'b0;
			for (int i = 0; i < PORTS; i++) begin
				if (i != rsq_pkg::PORT_UNDEF_IDX) begin
					d.portLatch[i*8 +: 8] =
						rsq_pkg::PORT_LATCH_RESET;
				end
				d.portDir[i*8 +: 8] = rsq_pkg::PORT_DIR_RESET;
			end
			d.osc_settle_time_select = rsq_pkg::OSC_SETTLE_TIME_SELECT_RESET;
			d.clkCtl = {4{rsq_pkg::CLK_REG_RESET}};
			d.memSize = {rsq_pkg::IMS_RESET, rsq_pkg::IXS_RESET};
		end

		// Probe counts ring ticks inside the clock stop
		if (q.st != rsq_pkg::ST_CLKSTOP) begin
			d.probeTicks = '0;
		end else if (q.tick) begin
			d.probeTicks = q.probeTicks + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk) begin
		if (!nrst) begin
			q <= '0;
			q.st <= rsq_pkg::ST_RESET;
			q.extSync <= 3'h7;
			q.portDir <= '1;
			q.osc_settle_time_select <= rsq_pkg::OSC_SETTLE_TIME_SELECT_RESET;
			q.memSize <= {rsq_pkg::IMS_RESET, rsq_pkg::IXS_RESET};
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	// Pins float through reset, clock stop and the reset settle wait
	assign hiZ = (q.st == rsq_pkg::ST_RESET) ||
		(q.st == rsq_pkg::ST_CLKSTOP) ||
		(q.st == rsq_pkg::ST_WAKE && q.fromStop);
	assign portOe = hiZ ? '0 : ~q.portDir;
	assign portOut = q.portLatch;
	// Indicator always drives: low in reset, software raises it
	assign resetIndOe = 1'b1;
	assign resetIndOut = q.ind & ~hiZ;

	assign coreReset = hiZ;
	assign cpuClkEn = (q.st == rsq_pkg::ST_RUN);
	assign ringOscRun = ~q.extReq;
	assign mainOscRun = ~q.extReq & (q.st != rsq_pkg::ST_STOP);
	assign vectorFetch = q.vecP;
	assign pcLoadAddr = rsq_pkg::RESET_VECTOR_ADDR;
	assign pswInit = rsq_pkg::PSW_RESET;
	assign wakeVector = q.wakeVecP;
	assign wakeResume = q.wakeResP;
	assign retainStop = q.fromStop & ((q.st == rsq_pkg::ST_RESET) ||
		(q.st == rsq_pkg::ST_WAKE));
	assign watchdogUnitReset = (q.st == rsq_pkg::ST_RESET);
	assign lowVoltageUnitReset = (q.st == rsq_pkg::ST_RESET) &
		~q.cause[0];
	assign clkCtlOut = q.clkCtl;
	assign memSizeOut = q.memSize;
	assign oscSettleSel = q.osc_settle_time_select;

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready = access;
	assign prdata = q.rdata;
	assign pslverr = access & ~regMapped(paddr);

	////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	pin_stop_settle_a: assert property (
		q.st == rsq_pkg::ST_STOP && q.extReq
		|=> q.st == rsq_pkg::ST_WAKE && retainStop)
		else $error("pin reset in stop skipped settle wait");

	masked_irq_hold_a: assert property (
		q.st == rsq_pkg::ST_STOP && !anyReq && irqReq && irqMaskFlag
		|=> q.st == rsq_pkg::ST_STOP)
		else $error("masked interrupt left deep stop");

	source_to_reset_a: assert property (
		q.st == rsq_pkg::ST_RUN && (watchdogOverflow || clockFailure)
		|=> q.st == rsq_pkg::ST_RESET ##1 coreReset)
		else $error("internal source did not reset");

	vector_after_stop_a: assert property (
		vectorFetch |-> q.probeTicks == 8'(rsq_pkg::RING_STOP_PERIODS)
		&& cpuClkEn && $past(q.st) == rsq_pkg::ST_CLKSTOP)
		else $error("clock stop not seventeen ring periods");

	float_in_reset_a: assert property (
		coreReset |-> portOe == '0 && !resetIndOut && resetIndOe)
		else $error("pins driven during reset");

	osc_stop_pin_a: assert property (
		q.extReq |-> !ringOscRun && !mainOscRun
		&& (!$past(q.extReq) || !q.tick))
		else $error("oscillator runs under pin reset");

	lvi_spared_a: assert property (
		q.st == rsq_pkg::ST_RESET && $past(q.lviReq, 2)
		&& $past(q.st, 2) == rsq_pkg::ST_RESET
		|-> !lowVoltageUnitReset)
		else $error("low-voltage reset hit its own detector");

	reset_reload_a: assert property (
		q.st == rsq_pkg::ST_RESET ##1 q.st == rsq_pkg::ST_RESET
		|-> oscSettleSel == rsq_pkg::OSC_SETTLE_TIME_SELECT_RESET && clkCtlOut == '0
		&& memSizeOut == {rsq_pkg::IMS_RESET, rsq_pkg::IXS_RESET})
		else $error("reset values not reloaded");

	sync_release_a: assert property (
		q.st == rsq_pkg::ST_RESET ##1 q.st == rsq_pkg::ST_CLKSTOP
		|-> $past(q.tick) && $past(!anyReq))
		else $error("release not aligned to ring tick");

	wake_settle_a: assert property (
		(wakeVector || wakeResume) |-> $past(q.st) == rsq_pkg::ST_WAKE
		&& $past(q.cnt) == settleCyc - 16'h0001)
		else $error("interrupt wake before settle time");

endmodule : rsq_reset_sequencer
